// ---- pcd_defines.svh ----
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH

// ****************************************
// Pin numbering
// ****************************************
`define PCD_NPIN 15
`define PCD_C_BASE 0
`define PCD_D_BASE 7
`define PCD_C_RESET 6
`define PCD_C_SCL 5
`define PCD_C_SDA 4
`define PCD_D_CMP_MINUS 7
`define PCD_D_T0A 6
`define PCD_D_T0B 5
`define PCD_D_XCK 4
`define PCD_D_T2B 3
`define PCD_D_IRQ0 2
`define PCD_D_TXD 1
`define PCD_D_RXD 0

// ****************************************
// Timing
// ****************************************
`define PCD_CLK_PERIOD_NS 10
`define PCD_SPIKE_NS 50
`define PCD_SPIKE_CYC ((`PCD_SPIKE_NS + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS)

// ****************************************
// Register offsets
// ****************************************
`define PCD_REG_CTRL 8'h00
`define PCD_REG_DRIVE 8'h04
`define PCD_REG_MASK 8'h08
`define PCD_REG_ANALOG 8'h0C
`define PCD_REG_STATUS 8'h10

// ****************************************
// Control fields
// ****************************************
`define PCD_CTRL_TWO_WIRE 0
`define PCD_CTRL_TX_EN 1
`define PCD_CTRL_RX_EN 2
`define PCD_CTRL_SYNC_MODE 3
`define PCD_CTRL_T0A_EN 4
`define PCD_CTRL_T0B_EN 5
`define PCD_CTRL_T2B_EN 6
`define PCD_CTRL_IRQ0_EN 7
`define PCD_CTRL_IRQ1_EN 8
`define PCD_CTRL_GROUP1 9
`define PCD_CTRL_GROUP2 10

// ****************************************
// Drive fields
// ****************************************
`define PCD_DRV_SCL 0
`define PCD_DRV_SDA 1
`define PCD_DRV_TXD 2
`define PCD_DRV_XCK 3
`define PCD_DRV_T0A 4
`define PCD_DRV_T0B 5
`define PCD_DRV_T2B 6

// ****************************************
// Reset values
// ****************************************
`define PCD_CTRL_RST 11'h000
`define PCD_DRIVE_RST 7'h00
`define PCD_MASK_RST 15'h0000
`define PCD_ANALOG_RST 6'h00

`endif

// ---- pcd_pkg.sv ----
package pcd_pkg;
  typedef logic [6:0] pcd_portc_t;
  typedef logic [7:0] pcd_portd_t;
  typedef logic [14:0] pcd_pins_t;
  typedef logic [2:0] pcd_spike_cnt_t;
endpackage

// ---- pcd_link_if.sv ----
`timescale 1ns/1ps

interface pcd_link_if;
  import pcd_pkg::*;
  // Peripheral controls toward the pin mux
  logic two_wire_enable;
  logic scl_drive;
  logic sda_drive;
  logic uart_tx_enable;
  logic uart_rx_enable;
  logic uart_mode_select;
  logic uart_tx_data;
  logic uart_sync_clock_out;
  logic timer0_compare_a_en;
  logic timer0_compare_a_out;
  logic timer0_compare_b_en;
  logic timer0_compare_b_out;
  logic timer2_compare_b_en;
  logic timer2_compare_b_out;
  logic ext_irq0_en;
  logic ext_irq1_en;
  logic pin_change_group1_en;
  logic pin_change_group2_en;
  pcd_portc_t pin_change_mask_c;
  pcd_portd_t pin_change_mask_d;
  logic [5:0] analog_input_buffer_off;
  // Routed inputs toward the peripherals
  logic scl_in;
  logic sda_in;
  logic uart_rx_in;
  logic uart_sync_clock_in;
  logic counter0_ext_input;
  logic counter1_ext_input;
  logic ext_irq0_in;
  logic ext_irq1_in;
  pcd_portc_t pin_change_src_c;
  pcd_portd_t pin_change_src_d;

  modport mux (
    input two_wire_enable, scl_drive, sda_drive, uart_tx_enable, uart_rx_enable,
    input uart_mode_select, uart_tx_data, uart_sync_clock_out,
    input timer0_compare_a_en, timer0_compare_a_out, timer0_compare_b_en,
    input timer0_compare_b_out, timer2_compare_b_en, timer2_compare_b_out,
    input ext_irq0_en, ext_irq1_en, pin_change_group1_en, pin_change_group2_en,
    input pin_change_mask_c, pin_change_mask_d, analog_input_buffer_off,
    output scl_in, sda_in, uart_rx_in, uart_sync_clock_in,
    output counter0_ext_input, counter1_ext_input, ext_irq0_in, ext_irq1_in,
    output pin_change_src_c, pin_change_src_d
  );

  modport periph (
    output two_wire_enable, scl_drive, sda_drive, uart_tx_enable, uart_rx_enable,
    output uart_mode_select, uart_tx_data, uart_sync_clock_out,
    output timer0_compare_a_en, timer0_compare_a_out, timer0_compare_b_en,
    output timer0_compare_b_out, timer2_compare_b_en, timer2_compare_b_out,
    output ext_irq0_en, ext_irq1_en, pin_change_group1_en, pin_change_group2_en,
    output pin_change_mask_c, pin_change_mask_d, analog_input_buffer_off,
    input scl_in, sda_in, uart_rx_in, uart_sync_clock_in,
    input counter0_ext_input, counter1_ext_input, ext_irq0_in, ext_irq1_in,
    input pin_change_src_c, pin_change_src_d
  );
endinterface

// ---- pcd_periph_ctl.sv ----
`timescale 1ns/1ps
`include "pcd_defines.svh"

module pcd_periph_ctl
  import pcd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pcd_link_if.periph lnk
);

  // ****************************************
  // Register state
  // ****************************************
  logic [10:0] ctrl;
  logic [10:0] next_ctrl;
  logic [6:0] drive;
  logic [6:0] next_drive;
  logic [14:0] mask;
  logic [14:0] next_mask;
  logic [5:0] analog;
  logic [5:0] next_analog;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] status;
  logic commit;
  logic hit;

  // ****************************************
  // Bus decode and register update
  // ****************************************
  always_comb begin
    status = {8'h00, lnk.pin_change_src_d, 1'b0, lnk.pin_change_src_c,
              lnk.ext_irq1_in, lnk.ext_irq0_in, lnk.counter1_ext_input,
              lnk.counter0_ext_input, lnk.uart_sync_clock_in, lnk.uart_rx_in,
              lnk.sda_in, lnk.scl_in};
    hit = (paddr == `PCD_REG_CTRL) || (paddr == `PCD_REG_DRIVE) ||
          (paddr == `PCD_REG_MASK) || (paddr == `PCD_REG_ANALOG) ||
          (paddr == `PCD_REG_STATUS);
    commit = psel && penable && pready && pwrite && hit;
    next_ctrl = ctrl;
    next_drive = drive;
    next_mask = mask;
    next_analog = analog;
    if (commit && paddr == `PCD_REG_CTRL) begin
      next_ctrl = pwdata[10:0];
    end
    if (commit && paddr == `PCD_REG_DRIVE) begin
      next_drive = pwdata[6:0];
    end
    if (commit && paddr == `PCD_REG_MASK) begin
      next_mask = {pwdata[15:8], pwdata[6:0]};
    end
    if (commit && paddr == `PCD_REG_ANALOG) begin
      next_analog = pwdata[5:0];
    end
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !hit;
    next_prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `PCD_REG_CTRL: next_prdata = {21'h000000, ctrl};
        `PCD_REG_DRIVE: next_prdata = {25'h0000000, drive};
        `PCD_REG_MASK: next_prdata = {16'h0000, mask[14:7], 1'b0, mask[6:0]};
        `PCD_REG_ANALOG: next_prdata = {26'h0000000, analog};
        `PCD_REG_STATUS: next_prdata = status;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `PCD_CTRL_RST;
      drive <= `PCD_DRIVE_RST;
      mask <= `PCD_MASK_RST;
      analog <= `PCD_ANALOG_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      drive <= next_drive;
      mask <= next_mask;
      analog <= next_analog;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // Link outputs
  // ****************************************
  assign lnk.two_wire_enable = ctrl[`PCD_CTRL_TWO_WIRE];
  assign lnk.uart_tx_enable = ctrl[`PCD_CTRL_TX_EN];
  assign lnk.uart_rx_enable = ctrl[`PCD_CTRL_RX_EN];
  assign lnk.uart_mode_select = ctrl[`PCD_CTRL_SYNC_MODE];
  assign lnk.timer0_compare_a_en = ctrl[`PCD_CTRL_T0A_EN];
  assign lnk.timer0_compare_b_en = ctrl[`PCD_CTRL_T0B_EN];
  assign lnk.timer2_compare_b_en = ctrl[`PCD_CTRL_T2B_EN];
  assign lnk.ext_irq0_en = ctrl[`PCD_CTRL_IRQ0_EN];
  assign lnk.ext_irq1_en = ctrl[`PCD_CTRL_IRQ1_EN];
  assign lnk.pin_change_group1_en = ctrl[`PCD_CTRL_GROUP1];
  assign lnk.pin_change_group2_en = ctrl[`PCD_CTRL_GROUP2];
  assign lnk.scl_drive = drive[`PCD_DRV_SCL];
  assign lnk.sda_drive = drive[`PCD_DRV_SDA];
  assign lnk.uart_tx_data = drive[`PCD_DRV_TXD];
  assign lnk.uart_sync_clock_out = drive[`PCD_DRV_XCK];
  assign lnk.timer0_compare_a_out = drive[`PCD_DRV_T0A];
  assign lnk.timer0_compare_b_out = drive[`PCD_DRV_T0B];
  assign lnk.timer2_compare_b_out = drive[`PCD_DRV_T2B];
  assign lnk.pin_change_mask_c = mask[6:0];
  assign lnk.pin_change_mask_d = mask[14:7];
  assign lnk.analog_input_buffer_off = analog;

endmodule

// ---- pcd_pin_mux.sv ----
// How it works
// - Fuse forces pin six pull-up, input
// - Two-wire enable overrides C5/C4, drives low
// - C5..C0 input enable from gated source, analog-off
// - Two-wire enable limits C5/C4 slew rate
// - Spike filters guard two-wire clock, data inputs
// - Software sets comparator pins input, no pull-up
// - Software sets D6 direction for compare A
// - Software sets D5 direction for compare B
// - Software sets D3 direction for timer2 B
// - Compare pins also carry PWM waveform
// - Transmitter enable forces D1 output with data
// - Receiver enable forces D0 input, routes receiver
// - Receiver keeps D0 pull-up under data bit
// - Sync mode drives D4 clock; input feeds clock
// - D3/D2 input enable from irq or source
// - D7..D4, D1, D0 input enable from group2
// - D5 feeds counter1, D4 feeds counter0
// - Reset-pin mode reads C6 bits as zero
`timescale 1ns/1ps
`include "pcd_defines.svh"

module pcd_pin_mux
  import pcd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pcd_link_if.mux lnk,
  input wire logic reset_pin_disable_fuse,
  input wire logic global_pullup_off,
  input wire pcd_portc_t portc_out,
  input wire pcd_portc_t portc_dir,
  input wire pcd_portd_t portd_out,
  input wire pcd_portd_t portd_dir,
  input wire pcd_portc_t portc_pin_in,
  input wire pcd_portd_t portd_pin_in,
  output pcd_portc_t portc_pin_out,
  output pcd_portc_t portc_pin_oe_n,
  output pcd_portc_t portc_pullup_en,
  output pcd_portd_t portd_pin_out,
  output pcd_portd_t portd_pin_oe_n,
  output pcd_portd_t portd_pullup_en,
  output logic two_wire_slew_limit,
  output pcd_portc_t portc_out_read,
  output pcd_portc_t portc_dir_read,
  output pcd_portc_t portc_in_read,
  output pcd_portd_t portd_in_read
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  pcd_pins_t pin_meta;
  pcd_pins_t pin_sync;
  logic fuse_meta;
  logic fuse_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 15'h0000;
      pin_sync <= 15'h0000;
      fuse_meta <= 1'b0;
      fuse_sync <= 1'b0;
    end else begin
      pin_meta <= {portd_pin_in, portc_pin_in};
      pin_sync <= pin_meta;
      fuse_meta <= reset_pin_disable_fuse;
      fuse_sync <= fuse_meta;
    end
  end

  // ****************************************
  // Override tables
  // ****************************************
  pcd_pins_t pullup_override_en;
  pcd_pins_t pullup_override_val;
  pcd_pins_t direction_override_en;
  pcd_pins_t direction_override_val;
  pcd_pins_t pin_value_override_en;
  pcd_pins_t pin_value_override_val;
  pcd_pins_t input_enable_override_en;
  pcd_pins_t input_enable_override_val;
  pcd_portc_t gated_c;
  pcd_portd_t gated_d;
  logic two_wire;

  always_comb begin
    two_wire = lnk.two_wire_enable;
    gated_c = lnk.pin_change_mask_c & {7{lnk.pin_change_group1_en}};
    gated_d = lnk.pin_change_mask_d & {8{lnk.pin_change_group2_en}};
    pullup_override_en = 15'h0000;
    pullup_override_val = 15'h0000;
    direction_override_en = 15'h0000;
    direction_override_val = 15'h0000;
    pin_value_override_en = 15'h0000;
    pin_value_override_val = 15'h0000;
    input_enable_override_en = 15'h0000;
    input_enable_override_val = 15'h0000;
    // Port C analog channels
    for (int i = 0; i < 6; i++) begin
      input_enable_override_en[i] = gated_c[i] | lnk.analog_input_buffer_off[i];
      input_enable_override_val[i] = gated_c[i];
    end
    // Port C pin six
    pullup_override_en[`PCD_C_RESET] = fuse_sync;
    pullup_override_val[`PCD_C_RESET] = 1'b1;
    direction_override_en[`PCD_C_RESET] = fuse_sync;
    direction_override_val[`PCD_C_RESET] = 1'b0;
    input_enable_override_en[`PCD_C_RESET] = fuse_sync | gated_c[`PCD_C_RESET];
    input_enable_override_val[`PCD_C_RESET] = fuse_sync;
    // Port C two-wire pins
    pullup_override_en[`PCD_C_SCL] = two_wire;
    pullup_override_val[`PCD_C_SCL] = portc_out[`PCD_C_SCL] & ~global_pullup_off;
    direction_override_en[`PCD_C_SCL] = two_wire;
    direction_override_val[`PCD_C_SCL] = lnk.scl_drive;
    pin_value_override_en[`PCD_C_SCL] = two_wire;
    pin_value_override_val[`PCD_C_SCL] = 1'b0;
    pullup_override_en[`PCD_C_SDA] = two_wire;
    pullup_override_val[`PCD_C_SDA] = portc_out[`PCD_C_SDA] & ~global_pullup_off;
    direction_override_en[`PCD_C_SDA] = two_wire;
    direction_override_val[`PCD_C_SDA] = lnk.sda_drive;
    pin_value_override_en[`PCD_C_SDA] = two_wire;
    pin_value_override_val[`PCD_C_SDA] = 1'b0;
    // Port D input enables
    for (int i = 0; i < 8; i++) begin
      input_enable_override_en[`PCD_D_BASE + i] = gated_d[i];
      input_enable_override_val[`PCD_D_BASE + i] = 1'b1;
    end
    input_enable_override_en[`PCD_D_BASE + `PCD_D_T2B] = lnk.ext_irq1_en |
        gated_d[`PCD_D_T2B];
    input_enable_override_en[`PCD_D_BASE + `PCD_D_IRQ0] = lnk.ext_irq0_en |
        gated_d[`PCD_D_IRQ0];
    // Port D compare outputs, PWM included
    pin_value_override_en[`PCD_D_BASE + `PCD_D_T0A] = lnk.timer0_compare_a_en;
    pin_value_override_val[`PCD_D_BASE + `PCD_D_T0A] = lnk.timer0_compare_a_out;
    pin_value_override_en[`PCD_D_BASE + `PCD_D_T0B] = lnk.timer0_compare_b_en;
    pin_value_override_val[`PCD_D_BASE + `PCD_D_T0B] = lnk.timer0_compare_b_out;
    pin_value_override_en[`PCD_D_BASE + `PCD_D_T2B] = lnk.timer2_compare_b_en;
    pin_value_override_val[`PCD_D_BASE + `PCD_D_T2B] = lnk.timer2_compare_b_out;
    // Port D serial clock
    pin_value_override_en[`PCD_D_BASE + `PCD_D_XCK] = lnk.uart_mode_select;
    pin_value_override_val[`PCD_D_BASE + `PCD_D_XCK] = lnk.uart_sync_clock_out;
    // Port D transmit pin
    pullup_override_en[`PCD_D_BASE + `PCD_D_TXD] = lnk.uart_tx_enable;
    pullup_override_val[`PCD_D_BASE + `PCD_D_TXD] = 1'b0;
    direction_override_en[`PCD_D_BASE + `PCD_D_TXD] = lnk.uart_tx_enable;
    direction_override_val[`PCD_D_BASE + `PCD_D_TXD] = 1'b1;
    pin_value_override_en[`PCD_D_BASE + `PCD_D_TXD] = lnk.uart_tx_enable;
    pin_value_override_val[`PCD_D_BASE + `PCD_D_TXD] = lnk.uart_tx_data;
    // Port D receive pin
    pullup_override_en[`PCD_D_BASE + `PCD_D_RXD] = lnk.uart_rx_enable;
    pullup_override_val[`PCD_D_BASE + `PCD_D_RXD] = portd_out[`PCD_D_RXD] &
        ~global_pullup_off;
    direction_override_en[`PCD_D_BASE + `PCD_D_RXD] = lnk.uart_rx_enable;
    direction_override_val[`PCD_D_BASE + `PCD_D_RXD] = 1'b0;
  end

  // ****************************************
  // Pin resolution
  // ****************************************
  pcd_pins_t reg_out;
  pcd_pins_t reg_dir;
  pcd_pins_t eff_dir;
  pcd_pins_t eff_val;
  pcd_pins_t eff_pull;
  pcd_pins_t eff_die;
  pcd_pins_t din;
  pcd_pins_t next_pin_out;
  pcd_pins_t next_pin_oe_n;
  pcd_pins_t next_pullup;

  always_comb begin
    reg_out = {portd_out, portc_out};
    reg_dir = {portd_dir, portc_dir};
    for (int i = 0; i < `PCD_NPIN; i++) begin
      eff_dir[i] = direction_override_en[i] ? direction_override_val[i] : reg_dir[i];
      eff_val[i] = pin_value_override_en[i] ? pin_value_override_val[i] : reg_out[i];
      eff_pull[i] = pullup_override_en[i] ? pullup_override_val[i] :
          (reg_out[i] & ~reg_dir[i] & ~global_pullup_off);
      eff_die[i] = input_enable_override_en[i] ? input_enable_override_val[i] : 1'b1;
    end
    if (!fuse_sync) begin
      eff_dir[`PCD_C_RESET] = 1'b0;
      eff_val[`PCD_C_RESET] = 1'b0;
    end
    din = pin_sync & eff_die;
    next_pin_out = eff_val;
    next_pin_oe_n = ~eff_dir;
    next_pullup = eff_pull & ~eff_dir;
  end

  // ****************************************
  // Two-wire spike filters
  // ****************************************
  logic [1:0] filt;
  logic [1:0] next_filt;
  pcd_spike_cnt_t spike_cnt [2];
  pcd_spike_cnt_t next_spike_cnt [2];
  logic [1:0] raw_tw;

  always_comb begin
    raw_tw = {pin_sync[`PCD_C_SCL], pin_sync[`PCD_C_SDA]};
    next_filt = filt;
    for (int k = 0; k < 2; k++) begin
      next_spike_cnt[k] = 3'h0;
      if (raw_tw[k] != filt[k]) begin
        if (spike_cnt[k] == 3'(`PCD_SPIKE_CYC - 1)) begin
          next_filt[k] = raw_tw[k];
        end else begin
          next_spike_cnt[k] = spike_cnt[k] + 3'h1;
        end
      end
    end
  end

  // ****************************************
  // Read-back and routed inputs
  // ****************************************
  pcd_portc_t c_keep;

  always_comb begin
    c_keep = fuse_sync ? 7'h7F : 7'h3F;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt <= 2'h3;
      spike_cnt[0] <= 3'h0;
      spike_cnt[1] <= 3'h0;
      portc_pin_out <= 7'h00;
      portc_pin_oe_n <= 7'h7F;
      portc_pullup_en <= 7'h00;
      portd_pin_out <= 8'h00;
      portd_pin_oe_n <= 8'hFF;
      portd_pullup_en <= 8'h00;
      two_wire_slew_limit <= 1'b0;
      portc_out_read <= 7'h00;
      portc_dir_read <= 7'h00;
      portc_in_read <= 7'h00;
      portd_in_read <= 8'h00;
      lnk.scl_in <= 1'b1;
      lnk.sda_in <= 1'b1;
      lnk.uart_rx_in <= 1'b0;
      lnk.uart_sync_clock_in <= 1'b0;
      lnk.counter0_ext_input <= 1'b0;
      lnk.counter1_ext_input <= 1'b0;
      lnk.ext_irq0_in <= 1'b0;
      lnk.ext_irq1_in <= 1'b0;
      lnk.pin_change_src_c <= 7'h00;
      lnk.pin_change_src_d <= 8'h00;
    end else begin
      filt <= next_filt;
      spike_cnt[0] <= next_spike_cnt[0];
      spike_cnt[1] <= next_spike_cnt[1];
      portc_pin_out <= next_pin_out[6:0];
      portc_pin_oe_n <= next_pin_oe_n[6:0];
      portc_pullup_en <= next_pullup[6:0];
      portd_pin_out <= next_pin_out[14:7];
      portd_pin_oe_n <= next_pin_oe_n[14:7];
      portd_pullup_en <= next_pullup[14:7];
      two_wire_slew_limit <= two_wire;
      portc_out_read <= portc_out & c_keep;
      portc_dir_read <= portc_dir & c_keep;
      portc_in_read <= din[6:0] & c_keep;
      portd_in_read <= din[14:7];
      lnk.scl_in <= filt[1];
      lnk.sda_in <= filt[0];
      lnk.uart_rx_in <= din[`PCD_D_BASE + `PCD_D_RXD];
      lnk.uart_sync_clock_in <= din[`PCD_D_BASE + `PCD_D_XCK];
      lnk.counter0_ext_input <= din[`PCD_D_BASE + `PCD_D_XCK];
      lnk.counter1_ext_input <= din[`PCD_D_BASE + `PCD_D_T0B];
      lnk.ext_irq0_in <= din[`PCD_D_BASE + `PCD_D_IRQ0];
      lnk.ext_irq1_in <= din[`PCD_D_BASE + `PCD_D_T2B];
      lnk.pin_change_src_c <= din[6:0];
      lnk.pin_change_src_d <= din[14:7];
    end
  end

endmodule

// ---- pcd_link_monitor.sv ----
`timescale 1ns/1ps
module pcd_link_monitor
  import pcd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic two_wire_enable,
  input wire logic scl_drive,
  input wire logic uart_tx_enable,
  input wire logic uart_tx_data,
  input wire logic uart_rx_enable,
  input wire logic uart_mode_select,
  input wire logic uart_sync_clock_out,
  input wire logic timer0_compare_a_en,
  input wire logic timer0_compare_a_out,
  input wire logic reset_pin_disable_fuse,
  input wire pcd_portc_t portc_pin_out,
  input wire pcd_portc_t portc_pin_oe_n,
  input wire pcd_portc_t portc_pullup_en,
  input wire pcd_portd_t portd_pin_out,
  input wire pcd_portd_t portd_pin_oe_n,
  input wire pcd_portd_t portd_pullup_en,
  input wire logic two_wire_slew_limit,
  input wire pcd_portc_t portc_out_read,
  input wire pcd_portc_t portc_dir_read
);
  logic [2:0] up;
  logic [2:0] next_up;
  always_comb next_up = (up == 3'h7) ? up : up + 3'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up <= 3'h0;
    else up <= next_up;
  end
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_tx_forced_out: assert property ($past(uart_tx_enable) |->
    !portd_pin_oe_n[1] && !portd_pullup_en[1] && portd_pin_out[1] == $past(uart_tx_data))
    else $error("tx pin wrong");
  a_rx_forced_in: assert property ($past(uart_rx_enable) |-> portd_pin_oe_n[0])
    else $error("rx pin driven");
  a_two_wire_low: assert property ($past(two_wire_enable) |->
    portc_pin_out[5:4] == 2'h0 && portc_pin_oe_n[5] == !$past(scl_drive))
    else $error("two wire pin wrong");
  a_slew_follow: assert property (two_wire_slew_limit == $past(two_wire_enable))
    else $error("slew limit wrong");
  a_compare_value: assert property ($past(timer0_compare_a_en) |->
    portd_pin_out[6] == $past(timer0_compare_a_out)) else $error("compare pin wrong");
  a_sync_clock: assert property ($past(uart_mode_select) |->
    portd_pin_out[4] == $past(uart_sync_clock_out)) else $error("sync clock wrong");
  a_reset_pin_read: assert property (up > 3'h4 && !$past(reset_pin_disable_fuse, 3) &&
    !$past(reset_pin_disable_fuse, 4) |-> portc_dir_read[6] == 1'h0 && portc_out_read[6] == 1'h0)
    else $error("reset pin reads set");
  a_fuse_pullup: assert property (up > 3'h4 && $past(reset_pin_disable_fuse, 3) &&
    $past(reset_pin_disable_fuse, 4) |-> portc_pullup_en[6] && portc_pin_oe_n[6])
    else $error("fuse pin wrong");
endmodule

// ---- port_c_d_alt_function_override_tb.sv ----
`timescale 1ns/1ps
`include "pcd_defines.svh"
`define CHK(n, e, a) \
  check_count++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
  end
module port_c_d_alt_function_override_tb;
  import pcd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, two_wire_slew_limit;
  logic reset_pin_disable_fuse, global_pullup_off;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pcd_portc_t portc_out, portc_dir, portc_pin_in, portc_pin_out, portc_pin_oe_n;
  pcd_portc_t portc_pullup_en, portc_out_read, portc_dir_read, portc_in_read;
  pcd_portd_t portd_out, portd_dir, portd_pin_in, portd_pin_out, portd_pin_oe_n;
  pcd_portd_t portd_pullup_en, portd_in_read;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  pcd_link_if lnk ();
  pcd_periph_ctl pcd_periph_ctl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .lnk(lnk));
  pcd_pin_mux pcd_pin_mux_inst (.pclk, .presetn, .lnk(lnk), .reset_pin_disable_fuse,
    .global_pullup_off, .portc_out, .portc_dir, .portd_out, .portd_dir, .portc_pin_in,
    .portd_pin_in, .portc_pin_out, .portc_pin_oe_n, .portc_pullup_en, .portd_pin_out,
    .portd_pin_oe_n, .portd_pullup_en, .two_wire_slew_limit, .portc_out_read,
    .portc_dir_read, .portc_in_read, .portd_in_read);
  pcd_link_monitor pcd_link_monitor_inst (.pclk, .presetn,
    .two_wire_enable(lnk.two_wire_enable), .scl_drive(lnk.scl_drive),
    .uart_tx_enable(lnk.uart_tx_enable), .uart_tx_data(lnk.uart_tx_data),
    .uart_rx_enable(lnk.uart_rx_enable), .uart_mode_select(lnk.uart_mode_select),
    .uart_sync_clock_out(lnk.uart_sync_clock_out),
    .timer0_compare_a_en(lnk.timer0_compare_a_en),
    .timer0_compare_a_out(lnk.timer0_compare_a_out), .reset_pin_disable_fuse,
    .portc_pin_out, .portc_pin_oe_n, .portc_pullup_en, .portd_pin_out, .portd_pin_oe_n,
    .portd_pullup_en, .two_wire_slew_limit, .portc_out_read, .portc_dir_read);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_fuse();
    portc_out <= 7'h40;
    portc_dir <= 7'h40;
    portc_pin_in <= 7'h40;
    tick(6);
    `CHK("c6 read", 3'h0, {portc_out_read[6], portc_dir_read[6], portc_in_read[6]})
    reset_pin_disable_fuse <= 1'b1;
    tick(6);
    `CHK("c6 fuse", 4'hF, {portc_pin_oe_n[6], portc_pullup_en[6], portc_dir_read[6], portc_in_read[6]})
  endtask
  task automatic t_uart();
    portd_dir <= 8'h81;
    portd_out <= 8'h81;
    apb(1'b1, `PCD_REG_DRIVE, 32'h4);
    apb(1'b1, `PCD_REG_CTRL, 32'h6);
    tick(2);
    `CHK("tx pin", 3'h2, {portd_pin_oe_n[1], portd_pin_out[1], portd_pullup_en[1]})
    `CHK("rx pin", 2'h3, {portd_pin_oe_n[0], portd_pullup_en[0]})
    `CHK("plain d7", 2'h1, {portd_pin_oe_n[7], portd_pin_out[7]})
    global_pullup_off <= 1'b1;
    portd_pin_in <= 8'h01;
    tick(5);
    `CHK("rx pullup", 1'h0, portd_pullup_en[0])
    `CHK("rx route", 1'h1, lnk.uart_rx_in)
    apb(1'b1, `PCD_REG_CTRL, 32'h0);
    tick(2);
    `CHK("tx released", 1'h1, portd_pin_oe_n[1])
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'h1, err)
  endtask
  task automatic t_two_wire();
    portc_out <= 7'h30;
    portc_pin_in <= 7'h30;
    global_pullup_off <= 1'b0;
    apb(1'b1, `PCD_REG_DRIVE, 32'h1);
    apb(1'b1, `PCD_REG_CTRL, 32'h1);
    tick(10);
    `CHK("two wire", 5'h03, {portc_pin_out[5:4], portc_pin_oe_n[5:4], two_wire_slew_limit})
    `CHK("two wire pullup", 2'h1, portc_pullup_en[5:4])
    portc_pin_in <= 7'h10;
    tick(4);
    portc_pin_in <= 7'h30;
    repeat (12) begin
      @(posedge pclk);
      `CHK("spike held", 1'h1, lnk.scl_in)
    end
    portc_pin_in <= 7'h10;
    tick(12);
    `CHK("clock low", 1'h0, lnk.scl_in)
    `CHK("data high", 1'h1, lnk.sda_in)
  endtask
  task automatic t_timers();
    int pins[3] = '{6, 5, 3};
    portd_dir <= 8'h68;
    portd_out <= 8'h68;
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `PCD_REG_CTRL, 32'h10 << k);
      apb(1'b1, `PCD_REG_DRIVE, 32'h0);
      tick(2);
      `CHK("compare low", 1'h0, portd_pin_out[pins[k]])
      apb(1'b1, `PCD_REG_DRIVE, 32'h10 << k);
      tick(2);
      `CHK("compare high", 2'h1, {portd_pin_oe_n[pins[k]], portd_pin_out[pins[k]]})
    end
  endtask
  task automatic t_sync();
    apb(1'b1, `PCD_REG_CTRL, 32'h8);
    apb(1'b1, `PCD_REG_DRIVE, 32'h8);
    portd_pin_in <= 8'h30;
    tick(5);
    `CHK("sync clock out", 1'h1, portd_pin_out[4])
    apb(1'b0, `PCD_REG_STATUS, 32'h0);
    `CHK("clock and counters", 3'h7, rd[5:3])
  endtask
  task automatic t_irq();
    portd_dir <= 8'h00;
    portd_out <= 8'h00;
    apb(1'b1, `PCD_REG_CTRL, 32'h580);
    apb(1'b1, `PCD_REG_MASK, 32'hFF00);
    apb(1'b1, `PCD_REG_ANALOG, 32'h1);
    portd_pin_in <= 8'hCD;
    portc_pin_in <= 7'h03;
    tick(5);
    `CHK("pin change d", 8'hCD, lnk.pin_change_src_d)
    `CHK("d inputs", 8'hCD, portd_in_read)
    `CHK("comparator pins", 4'hC, {portd_pin_oe_n[7:6], portd_pullup_en[7:6]})
    `CHK("analog off", 2'h2, portc_in_read[1:0])
    apb(1'b0, `PCD_REG_STATUS, 32'h0);
    `CHK("irq inputs", 2'h3, rd[7:6])
    apb(1'b1, `PCD_REG_CTRL, 32'h780);
    apb(1'b1, `PCD_REG_MASK, 32'hFF01);
    tick(5);
    `CHK("group1 source", 2'h3, portc_in_read[1:0])
    `CHK("pin change c", 7'h03, lnk.pin_change_src_c)
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {reset_pin_disable_fuse, global_pullup_off} = 2'h0;
    {portc_out, portc_dir, portc_pin_in} = '0;
    {portd_out, portd_dir, portd_pin_in} = '0;
    presetn = 1'b0;
    tick(8);
    presetn <= 1'b1;
    t_fuse();
    t_uart();
    t_two_wire();
    t_timers();
    t_sync();
    t_irq();
    complete_run();
  end
endmodule
